// [rtl/dpl_lock_ctrl.sv]
// What this block does
// - Opcodes F1..F6 are set password, unlock, erase prepare, erase unit, freeze, disable.
// - Security commands run only while the storage-security subsystem is inactive.
// - Locked mode rejects media access until an unlock or erase unit succeeds.
// - With no user password the device comes up unlocked; unlocked accepts all commands.
// - Freeze lock enters frozen mode, blocking password changes until power-off.
// - At high level the master password also unlocks a user-locked device.
// - At maximum level the master password unlocks only through erase unit, erasing data.
// - Setting the master password never enables locking but it can still unlock.
// - Setting the user password enables locking from the next power-on.
// - With setting preservation off, COMRESET also locks when a user password is set.
// - Setting the master password updates the 16-bit revision code shown in word 92.
// - The revision code stays in 0001h..FFFEh and defaults to FFFEh.
// - Every failed comparison, master or user, bumps one mismatch counter.
// - At five mismatches the exhausted flag sets and unlock and erase unit abort.
// - Power-on reset clears the mismatch counter and the exhausted flag.
`timescale 1ns/1ps
module dpl_lock_ctrl
    import dpl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nv_rst_n,
    input wire logic cmd_valid,
    input wire dpl_cmd_t cmd,
    output logic cmd_ready,
    output dpl_rsp_t rsp_q,
    input wire logic comreset,
    input wire logic ssp_enable,
    input wire logic tcg_active,
    input wire logic media_req,
    output logic media_reject,
    output logic locked,
    output logic frozen,
    output logic lock_enabled,
    output logic level_max,
    output logic attempts_exhausted_flag,
    output logic [15:0] rev_code,
    output logic erase_pulse_q
);

    dpl_state_t state_q;
    dpl_cmd_t cmd_q;
    logic boot_q;
    logic locked_q;
    logic frozen_q;
    logic prep_q;
    logic user_set_q;
    logic level_max_q;
    logic [15:0] rev_q;
    logic [2:0] miss_q;
    logic exhausted_q;
    logic take;
    logic match;
    logic [PW_W-1:0] rd_data;
    logic ok;
    logic fail_cnt;
    logic do_unlock;
    logic do_erase;
    logic wr_en;
    logic clr_user;

    ////////////////////////////////////////////////////////////////////////
    // command intake

    // one command at a time, none before the lock state is loaded
    assign cmd_ready = (state_q == DPL_IDLE) && !boot_q;
    assign take = cmd_valid && cmd_ready;

    // state sequence
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= DPL_IDLE;
        end
        else
        begin
            unique case (state_q)
                DPL_IDLE: state_q <= take ? DPL_EXEC : DPL_IDLE;
                DPL_EXEC: state_q <= DPL_IDLE;
                default: state_q <= DPL_IDLE;
            endcase
        end
    end

    // latch the command
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_q <= '0;
        end
        else if (take)
        begin
            cmd_q <= cmd;
        end
    end

    // password store, read launched at intake
    dpl_pw_store #(
        .WIDTH(PW_W)
    ) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_en),
        .wr_slot(cmd_q.is_master),
        .wr_data(cmd_q.password),
        .rd_en(take),
        .rd_slot(cmd.is_master),
        .rd_data_q(rd_data)
    );

    assign match = (rd_data == cmd_q.password);

    ////////////////////////////////////////////////////////////////////////
    // command decision

    // outcome of the latched command in the execute cycle
    always_comb
    begin
        ok = 1'b0;
        fail_cnt = 1'b0;
        do_unlock = 1'b0;
        do_erase = 1'b0;
        wr_en = 1'b0;
        clr_user = 1'b0;
        if (state_q == DPL_EXEC && !tcg_active)
        begin
            unique case (cmd_q.opcode)
                OP_SET_PW:
                begin
                    // no password changes while locked or frozen
                    ok = !locked_q && !frozen_q;
                    wr_en = ok;
                end
                OP_UNLOCK:
                begin
                    if (!exhausted_q && !frozen_q)
                    begin
                        // master unlock only at high level
                        if (cmd_q.is_master && level_max_q && user_set_q)
                        begin
                            ok = 1'b0;
                        end
                        else if (match && (cmd_q.is_master || user_set_q))
                        begin
                            ok = 1'b1;
                            do_unlock = 1'b1;
                        end
                        else
                        begin
                            fail_cnt = 1'b1;
                        end
                    end
                end
                OP_ERASE_PREP:
                begin
                    ok = !frozen_q;
                end
                OP_ERASE_UNIT:
                begin
                    if (!exhausted_q && !frozen_q && prep_q)
                    begin
                        if (match && (cmd_q.is_master || user_set_q))
                        begin
                            ok = 1'b1;
                            do_unlock = 1'b1;
                            do_erase = 1'b1;
                            clr_user = 1'b1;
                        end
                        else
                        begin
                            fail_cnt = 1'b1;
                        end
                    end
                end
                OP_FREEZE:
                begin
                    ok = !locked_q;
                end
                OP_DISABLE_PW:
                begin
                    if (!locked_q && !frozen_q)
                    begin
                        if (cmd_q.is_master && level_max_q)
                        begin
                            ok = 1'b0;
                        end
                        else if (match && (cmd_q.is_master || user_set_q))
                        begin
                            ok = 1'b1;
                            clr_user = 1'b1;
                        end
                        else
                        begin
                            fail_cnt = 1'b1;
                        end
                    end
                end
                default: ok = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // volatile lock state

    // lock mode loaded one cycle after power-on release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_q <= 1'b1;
            locked_q <= 1'b0;
        end
        else if (boot_q)
        begin
            boot_q <= 1'b0;
            locked_q <= user_set_q;
        end
        else if (comreset && !ssp_enable && user_set_q)
        begin
            locked_q <= 1'b1;
        end
        else if (do_unlock)
        begin
            locked_q <= 1'b0;
        end
    end

    // frozen until power-off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frozen_q <= 1'b0;
        end
        else if (ok && cmd_q.opcode == OP_FREEZE)
        begin
            frozen_q <= 1'b1;
        end
    end

    // erase unit must directly follow erase prepare
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prep_q <= 1'b0;
        end
        else if (comreset)
        begin
            prep_q <= 1'b0;
        end
        else if (state_q == DPL_EXEC)
        begin
            prep_q <= ok && cmd_q.opcode == OP_ERASE_PREP;
        end
    end

    // mismatch counter and exhausted flag, cleared only by power-on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            miss_q <= MISMATCH_RST;
            exhausted_q <= 1'b0;
        end
        else if (fail_cnt && miss_q != MISMATCH_LIMIT)
        begin
            miss_q <= miss_q + 3'h1;
            exhausted_q <= (miss_q + 3'h1) == MISMATCH_LIMIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settings kept across power-on

    // user password presence and level
    always_ff @(posedge clk or negedge nv_rst_n)
    begin
        if (!nv_rst_n)
        begin
            user_set_q <= 1'b0;
            level_max_q <= 1'b0;
        end
        else if (wr_en && !cmd_q.is_master)
        begin
            user_set_q <= 1'b1;
            level_max_q <= cmd_q.level_max;
        end
        else if (clr_user)
        begin
            user_set_q <= 1'b0;
            level_max_q <= 1'b0;
        end
    end

    // master revision code, invalid codes leave it unchanged
    always_ff @(posedge clk or negedge nv_rst_n)
    begin
        if (!nv_rst_n)
        begin
            rev_q <= REV_DEFAULT;
        end
        else if (wr_en && cmd_q.is_master && cmd_q.rev_code != REV_RSVD_LO
                 && cmd_q.rev_code != REV_RSVD_HI)
        begin
            rev_q <= cmd_q.rev_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answers

    // completion and erase strobes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_q <= '0;
            erase_pulse_q <= 1'b0;
        end
        else
        begin
            rsp_q.done <= state_q == DPL_EXEC;
            rsp_q.abort <= state_q == DPL_EXEC && !ok;
            erase_pulse_q <= do_erase;
        end
    end

    // media gate and status
    assign media_reject = media_req && (locked_q || boot_q);
    assign locked = locked_q;
    assign frozen = frozen_q;
    assign lock_enabled = user_set_q;
    assign level_max = level_max_q;
    assign attempts_exhausted_flag = exhausted_q;
    assign rev_code = rev_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_tcg_aborts: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == DPL_EXEC && tcg_active) |=> rsp_q.done && rsp_q.abort)
        else $error("command ran while storage security active");

    a_locked_media: assert property (@(posedge clk) disable iff (!rst_n)
        (media_req && locked_q) |-> media_reject)
        else $error("media access passed while locked");

    a_unlock_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == DPL_EXEC && cmd_q.opcode == OP_UNLOCK && ok && !boot_q && !comreset)
        |=> !locked_q)
        else $error("successful unlock left device locked");

    a_frozen_sticks: assert property (@(posedge clk) disable iff (!rst_n)
        frozen_q |=> frozen_q)
        else $error("frozen mode left without power-off");

    a_frozen_no_set: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == DPL_EXEC && frozen_q && cmd_q.opcode == OP_SET_PW)
        |=> rsp_q.abort ##0 $stable(rev_q))
        else $error("password changed in frozen mode");

    a_max_master: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == DPL_EXEC && cmd_q.opcode == OP_UNLOCK && cmd_q.is_master
         && level_max_q && user_set_q) |=> rsp_q.abort && locked_q == $past(locked_q))
        else $error("master unlock at maximum level");

    a_erase_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        erase_pulse_q |-> rsp_q.done && !rsp_q.abort && !locked_q)
        else $error("erase without successful erase unit");

    a_master_nolock: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && cmd_q.is_master) |=> user_set_q == $past(user_set_q))
        else $error("master password changed lock enable");

    a_comreset_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (comreset && !ssp_enable && user_set_q && !boot_q) |=> locked_q)
        else $error("comreset failed to lock");

    a_rev_valid: assert property (@(posedge clk) disable iff (!nv_rst_n)
        rev_q != REV_RSVD_LO && rev_q != REV_RSVD_HI)
        else $error("reserved revision code held");

    a_miss_count: assert property (@(posedge clk) disable iff (!rst_n)
        (fail_cnt && miss_q < MISMATCH_LIMIT) |=> miss_q == $past(miss_q) + 3'h1)
        else $error("mismatch not counted");

    a_exhaust_abort: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == DPL_EXEC && exhausted_q && (cmd_q.opcode == OP_UNLOCK
         || cmd_q.opcode == OP_ERASE_UNIT)) |=> rsp_q.abort ##1 exhausted_q)
        else $error("unlock or erase ran after attempts exhausted");

    a_exhaust_at5: assert property (@(posedge clk) disable iff (!rst_n)
        exhausted_q == (miss_q == MISMATCH_LIMIT))
        else $error("exhausted flag not tied to count of five");

endmodule : dpl_lock_ctrl

// [rtl/dpl_pkg.sv]
package dpl_pkg;

    // security opcodes
    localparam logic [7:0] OP_SET_PW = 8'hF1;
    localparam logic [7:0] OP_UNLOCK = 8'hF2;
    localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
    localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
    localparam logic [7:0] OP_FREEZE = 8'hF5;
    localparam logic [7:0] OP_DISABLE_PW = 8'hF6;

    // password width: 32 bytes
    localparam int PW_W = 256;

    // master revision code range and default
    localparam logic [15:0] REV_DEFAULT = 16'hFFFE;
    localparam logic [15:0] REV_RSVD_LO = 16'h0000;
    localparam logic [15:0] REV_RSVD_HI = 16'hFFFF;

    // mismatch limit
    localparam logic [2:0] MISMATCH_LIMIT = 3'h5;
    localparam logic [2:0] MISMATCH_RST = 3'h0;

    // password slots in the store
    localparam logic SLOT_USER = 1'b0;
    localparam logic SLOT_MASTER = 1'b1;

    // flag bit position in identify word 128
    localparam int EXHAUST_BIT = 4;

    typedef struct packed {
        logic [7:0] opcode;
        logic is_master;
        logic level_max;
        logic [15:0] rev_code;
        logic [PW_W-1:0] password;
    } dpl_cmd_t;

    typedef struct packed {
        logic done;
        logic abort;
    } dpl_rsp_t;

    typedef enum logic [1:0] {
        DPL_IDLE = 2'b01,
        DPL_EXEC = 2'b10
    } dpl_state_t;

endpackage : dpl_pkg

// [rtl/dpl_pw_store.sv]
`timescale 1ns/1ps
module dpl_pw_store
    import dpl_pkg::*;
#(
    parameter int WIDTH = PW_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic wr_slot,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic rd_slot,
    output logic [WIDTH-1:0] rd_data_q
);

    // two password slots, kept across power-on reset
    logic [WIDTH-1:0] mem [2];

    // write port
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_slot] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= '0;
        end
        else if (rd_en)
        begin
            rd_data_q <= mem[rd_slot];
        end
    end

endmodule : dpl_pw_store

// [dv/dpl_host_model.sv]
`timescale 1ns/1ps
module dpl_host_model
    import dpl_pkg::*;
(
    input wire logic clk,
    input wire logic cmd_ready,
    input wire dpl_rsp_t rsp_q,
    output logic cmd_valid,
    output dpl_cmd_t cmd
);
    ////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    ////////////////////////////////////////////////////////////////
    // offer one command, hold it until taken, then await its answer
    task automatic send(input logic [7:0] op, input logic m, input logic lv,
        input logic [15:0] rev, input logic [PW_W-1:0] pw, output logic seen);
        int n;
        seen = 1'b0;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd.opcode = op;
        cmd.is_master = m;
        cmd.level_max = lv;
        cmd.rev_code = rev;
        cmd.password = pw;
        // ready seen at the falling edge holds through the next rising one
        for (n = 0; n < 20; n++)
        begin
            @(negedge clk);
            if (cmd_ready === 1'b1)
                break;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd = ~cmd; // released bus shows no stale value
        for (n = 0; n < 10; n++)
        begin
            @(negedge clk);
            if (rsp_q.done === 1'b1)
            begin
                seen = 1'b1;
                break;
            end
        end
    endtask : send
endmodule : dpl_host_model

// [dv/dpl_lock_ctrl_tb_top.sv]
`timescale 1ns/1ps
module dpl_lock_ctrl_tb_top
    import dpl_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, nv_rst_n, comreset, ssp_enable, tcg_active, media_req;
    logic cmd_valid, cmd_ready, media_reject, locked, frozen, lock_enabled;
    logic level_max, attempts_exhausted_flag, erase_pulse_q, seen;
    logic [15:0] rev_code, rv;
    dpl_cmd_t cmd;
    dpl_rsp_t rsp_q;
    logic [PW_W-1:0] pm, pu, pbad;
    logic [31:0] lfsr_q;
    logic [1:0] note_q[$];
    logic [1:0] e;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    dpl_lock_ctrl uut (.clk(clk), .rst_n(rst_n), .nv_rst_n(nv_rst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_q(rsp_q),
        .comreset(comreset), .ssp_enable(ssp_enable), .tcg_active(tcg_active),
        .media_req(media_req), .media_reject(media_reject), .locked(locked),
        .frozen(frozen), .lock_enabled(lock_enabled), .level_max(level_max),
        .attempts_exhausted_flag(attempts_exhausted_flag), .rev_code(rev_code),
        .erase_pulse_q(erase_pulse_q));

    dpl_host_model host (.clk(clk), .cmd_ready(cmd_ready), .rsp_q(rsp_q),
        .cmd_valid(cmd_valid), .cmd(cmd));

    ////////////////////////////////////////////////////////////////
    // compare and report helpers
    task automatic chkb(input string nm, input logic ex, input logic got);
        n_tests++;
        if (got !== ex)
        begin
            errors++;
            $display("ERROR %s expected %b seen %b", nm, ex, got);
        end
    endtask : chkb

    task automatic chkw(input string nm, input logic [15:0] ex, input logic [15:0] got);
        n_tests++;
        if (got !== ex)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : chkw

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////
    // stimulus helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction : lfsr

    task automatic rpw(output logic [PW_W-1:0] p);
        for (int i = 0; i < 8; i++)
        begin
            lfsr_q = lfsr(lfsr_q);
            p[i*32 +: 32] = lfsr_q;
        end
    endtask : rpw

    // note the expected answer, then send the command
    task automatic cmd_do(input logic [7:0] op, input logic m, input logic lv,
        input logic [15:0] r, input logic [PW_W-1:0] pw, input logic ab, input logic er);
        note_q.push_back({ab, er});
        host.send(op, m, lv, r, pw, seen);
        chkb("answer", 1'b1, seen);
    endtask : cmd_do

    task automatic pwr();
        @(posedge clk);
        #1 rst_n = 1'b0;
        @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        @(negedge clk);
    endtask : pwr

    task automatic link_rst(input logic s);
        @(posedge clk);
        #1 ssp_enable = s;
        comreset = 1'b1;
        @(posedge clk);
        #1 comreset = 1'b0;
        @(negedge clk);
    endtask : link_rst

    ////////////////////////////////////////////////////////////////
    // answer monitor: oldest note against each finished command
    always @(negedge clk)
    begin
        if (rsp_q.done === 1'b1)
        begin
            if (note_q.size() == 0)
                chkb("spare done", 1'b0, 1'b1);
            else
            begin
                e = note_q.pop_front();
                chkb("abort", e[1], rsp_q.abort);
                chkb("erase", e[0], erase_pulse_q);
            end
        end
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {rst_n, nv_rst_n, comreset, ssp_enable, tcg_active, media_req} = '0;
        lfsr_q = 32'h0f4e_79f6;
        rpw(pm);
        rpw(pu);
        rpw(pbad);
        repeat (15) @(posedge clk);
        @(negedge clk);
        chkb("cmd_ready", 1'b0, cmd_ready);
        @(posedge clk);
        #1 {rst_n, nv_rst_n, media_req} = 3'b111;
        @(posedge clk);
        @(negedge clk);
        chkb("locked", 1'b0, locked);
        chkb("media_reject", 1'b0, media_reject);
        chkw("rev_code", 16'hfffe, rev_code);
        chkb("exhausted", 1'b0, attempts_exhausted_flag);
        chkb("cmd_ready", 1'b1, cmd_ready);
        @(posedge clk);
        #1 tcg_active = 1'b1;
        cmd_do(OP_FREEZE, 1'b0, 1'b0, 16'h0000, pm, 1'b1, 1'b0);
        chkb("frozen", 1'b0, frozen);
        @(posedge clk);
        #1 tcg_active = 1'b0;
        cmd_do(8'hf0, 1'b0, 1'b0, 16'h0000, pm, 1'b1, 1'b0);
        $display("test boot done");
        rv = lfsr_q[15:0];
        if (rv == 16'h0000 || rv == 16'hffff || rv == 16'hfffe)
            rv = 16'h0001;
        cmd_do(OP_SET_PW, 1'b1, 1'b0, rv, pm, 1'b0, 1'b0);
        chkw("rev_code", rv, rev_code);
        chkb("lock_enabled", 1'b0, lock_enabled);
        cmd_do(OP_SET_PW, 1'b1, 1'b0, 16'h0000, pm, 1'b0, 1'b0);
        chkw("rev_code", rv, rev_code);
        cmd_do(OP_SET_PW, 1'b1, 1'b0, 16'hffff, pm, 1'b0, 1'b0);
        chkw("rev_code", rv, rev_code);
        cmd_do(OP_SET_PW, 1'b0, 1'b0, 16'h0000, pu, 1'b0, 1'b0);
        chkb("lock_enabled", 1'b1, lock_enabled);
        chkb("locked", 1'b0, locked);
        link_rst(1'b1);
        chkb("locked", 1'b0, locked);
        link_rst(1'b0);
        chkb("locked", 1'b1, locked);
        chkb("media_reject", 1'b1, media_reject);
        cmd_do(OP_SET_PW, 1'b0, 1'b0, 16'h0000, pu, 1'b1, 1'b0);
        cmd_do(OP_FREEZE, 1'b0, 1'b0, 16'h0000, pu, 1'b1, 1'b0);
        cmd_do(OP_UNLOCK, 1'b1, 1'b0, 16'h0000, pm, 1'b0, 1'b0);
        chkb("locked", 1'b0, locked);
        chkb("media_reject", 1'b0, media_reject);
        $display("test passwords done");
        pwr();
        chkb("locked", 1'b1, locked);
        for (int i = 0; i < 5; i++)
        begin
            cmd_do(OP_UNLOCK, i[0], 1'b0, 16'h0000, pbad, 1'b1, 1'b0);
            chkb("exhausted", i == 4, attempts_exhausted_flag);
        end
        cmd_do(OP_UNLOCK, 1'b0, 1'b0, 16'h0000, pu, 1'b1, 1'b0);
        cmd_do(OP_ERASE_PREP, 1'b1, 1'b0, 16'h0000, pm, 1'b0, 1'b0);
        cmd_do(OP_ERASE_UNIT, 1'b1, 1'b0, 16'h0000, pm, 1'b1, 1'b0);
        pwr();
        chkb("exhausted", 1'b0, attempts_exhausted_flag);
        cmd_do(OP_UNLOCK, 1'b0, 1'b0, 16'h0000, pu, 1'b0, 1'b0);
        chkb("locked", 1'b0, locked);
        $display("test attempts done");
        cmd_do(OP_SET_PW, 1'b0, 1'b1, 16'h0000, pu, 1'b0, 1'b0);
        chkb("level_max", 1'b1, level_max);
        pwr();
        cmd_do(OP_UNLOCK, 1'b1, 1'b0, 16'h0000, pm, 1'b1, 1'b0);
        cmd_do(OP_ERASE_PREP, 1'b1, 1'b0, 16'h0000, pm, 1'b0, 1'b0);
        cmd_do(OP_ERASE_UNIT, 1'b1, 1'b0, 16'h0000, pm, 1'b0, 1'b1);
        chkb("locked", 1'b0, locked);
        chkb("lock_enabled", 1'b0, lock_enabled);
        $display("test maximum done");
        cmd_do(OP_SET_PW, 1'b0, 1'b0, 16'h0000, pu, 1'b0, 1'b0);
        cmd_do(OP_DISABLE_PW, 1'b0, 1'b0, 16'h0000, pbad, 1'b1, 1'b0);
        chkb("lock_enabled", 1'b1, lock_enabled);
        cmd_do(OP_DISABLE_PW, 1'b0, 1'b0, 16'h0000, pu, 1'b0, 1'b0);
        chkb("lock_enabled", 1'b0, lock_enabled);
        $display("test disable done");
        cmd_do(OP_FREEZE, 1'b0, 1'b0, 16'h0000, pm, 1'b0, 1'b0);
        chkb("frozen", 1'b1, frozen);
        for (int i = 0; i < 6; i++)
            if (i != 4)
                cmd_do(OP_SET_PW + i[7:0], 1'b1, 1'b0, 16'h0000, pm, 1'b1, 1'b0);
        pwr();
        chkb("frozen", 1'b0, frozen);
        $display("test freeze done");
        results();
    end
endmodule : dpl_lock_ctrl_tb_top
